// ==== src/instr_exec_pkg.sv ====
/*
 Constants, types and encodings for the three-instruction execution slice.
 Assumes a 14-bit instruction word, an 8-bit data path and a 13-bit program counter.
*/
`default_nettype none
package instr_exec_pkg;
   // ********************************
   // Widths
   // ********************************
   localparam int unsigned INSTR_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PC_W = 13;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned JUMP_W = 11;
   // ********************************
   // Field positions and encodings
   // ********************************
   localparam int unsigned DEST_BIT = 7;
   localparam int unsigned PAGE_LO_BIT = 3;
   localparam int unsigned PAGE_HI_BIT = 4;
   localparam logic [5:0] COMPLEMENT_CODE = 6'h09;
   localparam logic [5:0] INC_SKIP_CODE = 6'h0F;
   localparam logic [2:0] JUMP_CODE = 3'h5;
   // ********************************
   // Reset values
   // ********************************
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   // ********************************
   // Types
   // ********************************
   typedef enum logic [2:0]
   {
      EXEC_RUN = 3'b001,
      EXEC_FLUSH = 3'b010,
      EXEC_IDLE = 3'b100
   } exec_state_type;
   typedef struct packed
   {
      logic en;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } file_write_type;
endpackage : instr_exec_pkg
`default_nettype wire

// ==== src/instr_exec.sv ====
/*
 Execution slice of the core: complement, unconditional jump, increment-and-skip.
 Assumes program memory answers the fetch address in the same cycle, and that
 the register file reads combinationally at file_rd_addr.
*/
`default_nettype none
module instr_exec
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Program memory
   input wire logic [instr_exec_pkg::INSTR_W-1:0] instr_word,
   output logic [instr_exec_pkg::PC_W-1:0] program_counter,
   // Register file
   output logic [instr_exec_pkg::FADDR_W-1:0] file_rd_addr,
   input wire logic [instr_exec_pkg::DATA_W-1:0] file_rd_data,
   output instr_exec_pkg::file_write_type file_wr,
   // Core state
   input wire logic [instr_exec_pkg::DATA_W-1:0] program_page_latch,
   output logic [instr_exec_pkg::DATA_W-1:0] accumulator,
   output logic zero_flag,
   output logic squashed
);
   // ********************************
   // Decode
   // ********************************
   function automatic logic is_op6(input logic [13:0] w, input logic [5:0] code);
      return w[13:8] == code;
   endfunction : is_op6

   function automatic logic is_op3(input logic [13:0] w, input logic [2:0] code);
      return w[13:11] == code;
   endfunction : is_op3

   instr_exec_pkg::exec_state_type state_ff, nxt_state;
   logic [instr_exec_pkg::PC_W-1:0] pc_ff, nxt_pc;
   logic [instr_exec_pkg::DATA_W-1:0] acc_ff, nxt_acc;
   logic zero_ff, nxt_zero;
   logic squash_ff, nxt_squash;
   logic hold_ff, nxt_hold;
   instr_exec_pkg::file_write_type wr_ff, nxt_wr;
   logic [instr_exec_pkg::DATA_W-1:0] result;
   logic complement_file_op;
   logic unconditional_jump_op;
   logic increment_skip_zero_op;
   logic dest_file;

   assign complement_file_op = is_op6(instr_word, instr_exec_pkg::COMPLEMENT_CODE);
   assign increment_skip_zero_op = is_op6(instr_word, instr_exec_pkg::INC_SKIP_CODE);
   assign unconditional_jump_op = is_op3(instr_word, instr_exec_pkg::JUMP_CODE);
   assign dest_file = instr_word[instr_exec_pkg::DEST_BIT];
   assign file_rd_addr = instr_word[instr_exec_pkg::FADDR_W-1:0];

   // ********************************
   // Next state
   // ********************************
   always_comb
   begin
      nxt_state = state_ff;
      nxt_pc = pc_ff;
      nxt_acc = acc_ff;
      nxt_squash = 1'b0;
      nxt_wr = '0;
      result = '0;
      case (state_ff)
         instr_exec_pkg::EXEC_RUN:
         begin
            nxt_pc = pc_ff + 13'h0001;
            if (complement_file_op)
            begin
               result = ~file_rd_data;
               if (dest_file)
               begin
                  nxt_wr.en = 1'b1;
                  nxt_wr.addr = file_rd_addr;
                  nxt_wr.data = result;
               end
               else
               begin
                  nxt_acc = result;
               end
            end
            else if (increment_skip_zero_op)
            begin
               result = file_rd_data + 8'h01;
               if (dest_file)
               begin
                  nxt_wr.en = 1'b1;
                  nxt_wr.addr = file_rd_addr;
                  nxt_wr.data = result;
               end
               else
               begin
                  nxt_acc = result;
               end
               if (result == 8'h00)
               begin
                  nxt_state = instr_exec_pkg::EXEC_FLUSH;
               end
            end
            else if (unconditional_jump_op)
            begin
               nxt_pc = {program_page_latch[instr_exec_pkg::PAGE_HI_BIT:instr_exec_pkg::PAGE_LO_BIT],
                         instr_word[instr_exec_pkg::JUMP_W-1:0]};
               nxt_state = instr_exec_pkg::EXEC_FLUSH;
            end
         end
         instr_exec_pkg::EXEC_FLUSH:
         begin
            if (hold_ff)
            begin
               nxt_pc = pc_ff;
            end
            else
            begin
               nxt_pc = pc_ff + 13'h0001;
            end
            nxt_squash = 1'b1;
            nxt_state = instr_exec_pkg::EXEC_RUN;
         end
         default:
         begin
            nxt_state = instr_exec_pkg::EXEC_RUN;
         end
      endcase
   end

   // ********************************
   // Registers
   // ********************************
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= instr_exec_pkg::EXEC_RUN;
         pc_ff <= instr_exec_pkg::PC_RESET;
         acc_ff <= instr_exec_pkg::ACC_RESET;
         squash_ff <= 1'b0;
         wr_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         pc_ff <= nxt_pc;
         acc_ff <= nxt_acc;
         squash_ff <= nxt_squash;
         wr_ff <= nxt_wr;
      end
   end

   // ********************************
   // Zero flag
   // ********************************
   always_comb
   begin
      nxt_zero = zero_ff;
      if ((state_ff == instr_exec_pkg::EXEC_RUN) && complement_file_op)
      begin
         nxt_zero = (file_rd_data == 8'hFF);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         zero_ff <= 1'b0;
      end
      else
      begin
         zero_ff <= nxt_zero;
      end
   end

   // ********************************
   // Fetch hold after a jump
   // ********************************
   always_comb
   begin
      nxt_hold = 1'b0;
      if ((state_ff == instr_exec_pkg::EXEC_RUN) && !complement_file_op && !increment_skip_zero_op
          && unconditional_jump_op)
      begin
         nxt_hold = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hold_ff <= 1'b0;
      end
      else
      begin
         hold_ff <= nxt_hold;
      end
   end

   // ********************************
   // Outputs
   // ********************************
   assign program_counter = pc_ff;
   assign accumulator = acc_ff;
   assign zero_flag = zero_ff;
   assign squashed = squash_ff;
   assign file_wr = wr_ff;
endmodule : instr_exec
`default_nettype wire

// ==== tb/instr_exec_chk_sva.sv ====
/* Port checker for instr_exec.
 Assumes it is bound to instr_exec. */
`default_nettype none
module instr_exec_chk
(
   input wire logic sys_clk, reset_n, zero_flag, squashed,
   input wire logic [13:0] instr_word,
   input wire logic [12:0] program_counter,
   input wire logic [6:0] file_rd_addr,
   input wire logic [7:0] file_rd_data, program_page_latch, accumulator,
   input wire instr_exec_pkg::file_write_type file_wr
);
   timeunit 1ns;
   timeprecision 100ps;
   logic run_ff;
   wire cmp = run_ff && instr_word[13:8] == 6'h09;
   wire isk = run_ff && instr_word[13:8] == 6'h0F;
   wire jmp = run_ff && instr_word[13:11] == 3'h5;
   wire d = instr_word[7];
   wire wrap = file_rd_data == 8'hFF;
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
         run_ff <= 1'b1;
      else
         run_ff <= !(jmp || (isk && wrap));
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   sequence dropped_s;
      ##1 squashed && !file_wr.en;
   endsequence
   cmp_acc_a: assert property (cmp && !d |=> accumulator == ~$past(file_rd_data)) else $error("acc");
   cmp_wr_a: assert property (cmp && d |=>
      file_wr == {1'b1, $past(file_rd_addr), ~$past(file_rd_data)} && $stable(accumulator)) else $error("wr");
   cmp_zero_a: assert property (cmp |=> zero_flag == $past(wrap)) else $error("zero");
   jmp_pc_a: assert property (jmp |=>
      program_counter == {$past(program_page_latch[4:3]), $past(instr_word[10:0])} && $stable(zero_flag))
      else $error("jump");
   jmp_flush_a: assert property (jmp |=> dropped_s) else $error("flush");
   jmp_hold_a: assert property (jmp |=> ##1 program_counter == $past(program_counter)) else $error("hold");
   isk_acc_a: assert property (isk && !d |=>
      accumulator == {$past(file_rd_data) + 8'h01} && $stable(zero_flag)) else $error("inc");
   isk_skip_a: assert property (isk && wrap |=> dropped_s) else $error("skip");
   isk_step_a: assert property (isk && !wrap |=>
      program_counter == $past(program_counter) + 13'h0001 ##1 !squashed) else $error("step");
endmodule : instr_exec_chk
`default_nettype wire

// ==== tb/prog_mem.sv ====
/* Program memory model.
 Assumes the bench fills mem; answers in the same cycle. */
`default_nettype none
module prog_mem
(
   input wire logic [12:0] program_counter,
   output logic [13:0] instr_word
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [13:0] mem [8192];
   assign instr_word = mem[program_counter];
endmodule : prog_mem
`default_nettype wire

// ==== tb/tb_instr_exec.sv ====
/* Bench for instr_exec.
 Assumes checker and prog_mem compiled first. */
`default_nettype none
module tb_instr_exec;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] program_page_latch = 8'h00;
   logic [13:0] instr_word;
   logic [12:0] program_counter;
   logic [6:0] file_rd_addr;
   logic [7:0] accumulator, file_rd_data;
   logic [7:0] rf [128];
   instr_exec_pkg::file_write_type file_wr, wr_last;
   logic zero_flag, squashed;
   int err_total = 0;
   int compares = 0;
   assign file_rd_data = rf[file_rd_addr];
   always #10 sys_clk = ~sys_clk;
   prog_mem prog_mem_i (.*);
   instr_exec instr_exec_i (.*);
   always @(posedge sys_clk) if (file_wr.en) wr_last <= file_wr;
   task chk(input logic [15:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task go(input int n);
      reset_n <= 1'b0;
      wr_last <= '0;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : go
   task t_comp;
      prog_mem_i.mem[0] = 14'h0905;
      prog_mem_i.mem[1] = 14'h0986;
      rf[5] = 8'h13;
      rf[6] = 8'hFF;
      go(3);
      chk(accumulator, 8'hEC);
      chk(zero_flag, 1'b1);
      chk(wr_last, 16'h8600);
      $display("complement test done");
   endtask : t_comp
   task t_isk;
      prog_mem_i.mem[0] = 14'h0F87;
      prog_mem_i.mem[2] = 14'h0F08;
      rf[7] = 8'hFF;
      rf[8] = 8'h41;
      go(2);
      chk(zero_flag, 1'b0);
      chk(accumulator, 8'h00);
      chk(wr_last, 16'h8700);
      @(posedge sys_clk);
      #1;
      chk(accumulator, 8'h42);
      chk(program_counter, 16'h0003);
      $display("increment skip test done");
   endtask : t_isk
   task t_jump;
      @(posedge sys_clk) program_page_latch <= 8'h18;
      prog_mem_i.mem[0] = 14'h2FFF;
      prog_mem_i.mem[8191] = 14'h0905;
      go(1);
      chk(program_counter, 16'h1FFF);
      @(posedge sys_clk);
      #1;
      chk({squashed, zero_flag, accumulator}, 16'h0200);
      chk(program_counter, 16'h1FFF);
      @(posedge sys_clk);
      #1;
      chk(accumulator, 8'hEC);
      $display("jump test done");
   endtask : t_jump
   task conclude;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   initial
   begin
      for (int a = 0; a < 8192; a++) prog_mem_i.mem[a] = 14'h0000;
      for (int a = 0; a < 128; a++) rf[a] = 8'h00;
      t_comp;
      t_isk;
      t_jump;
      conclude;
   end
   initial
   begin
      #100us;
      err_total++;
      conclude;
   end
endmodule : tb_instr_exec
bind instr_exec instr_exec_chk instr_exec_chk_i (.*);
`default_nettype wire
